// *** verilog/eccp_unit.sv ***
/*
 * enhanced capture/compare/pwm unit with apb register access.
 * assumes timers one, two and three, the converter and the port
 * logic live outside; all inputs are synchronous to pclk.
 */
// Implementation choices: the placing of the registers and the APB interface to the registers.
// Notes on behaviour
// - one 16-bit data register serves capture, compare or pwm duty
// - mode 0000 switches everything off and resets internal state
// - modes 0001 and 0011 are reserved and enable nothing
// - mode 0010 toggles the pin and sets the flag on match
// - capture on falling, rising, every 4th or 16th rising edge
// - compare match sets, clears or leaves the pin; flag set always
// - mode 1011 sets flag, resets timer base, starts enabled conversion
// - modes 11xx are pwm; bit1 inverts a/c, bit0 inverts b/d
// - outside pwm the config is ignored; a is ccp pin, rest port
// - config 00: only a modulated, b c d port pins
// - config 01: d modulated, a active, b c inactive
// - config 10: a and b modulated, c d port pins
// - config 11: b modulated, c active, a d inactive
// - pwm duty is data low byte with control bits 5:4 below
// - control, data and config read and write; status reads, flag is write-one-to-clear; control resets to zero
// - capture/compare use timer one or three, pwm timer two
// - pwm frequency and update rate come from timer two
// - capture time base is chosen independently of other unit
// - pin steering by control pattern: one, two or four pins
// - dual and quad pwm override the parallel slave port
// - an assigned output reaches its pin only when direction is out
// - pwm control values take effect at the next period start
`timescale 1ns/1ps
module eccp_unit
    import eccp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // time bases
    input wire logic [15:0] timer_one,
    input wire logic [15:0] timer_three,
    input wire logic [7:0] timer_two,
    input wire logic [1:0] timer_two_phase,
    input wire logic timer_two_reset,
    output logic timer_one_clear,
    output logic timer_three_clear,
    // converter
    input wire logic adc_enabled,
    output logic adc_start,
    // capture input and shared pins
    input wire logic capture_pin_in,
    input wire port_side_t port_side,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    // flag
    output logic unit_irq_flag
);

    ////////////////////////////////////////////////////////////////////
    // registers

    unit_control_t unit_control_reg_ff;
    unit_control_t ctrl_act_ff;
    logic [7:0] unit_data_low_ff;
    logic [7:0] unit_data_high_ff;
    logic time_base_ff;
    logic irq_ff;
    logic [31:0] prdata_ff;
    logic [9:0] duty_act_ff;
    logic pwm_ff;
    logic pin_latch_ff;
    logic cap_prev_ff;
    logic cmp_eq_prev_ff;
    logic [3:0] presc_ff;
    logic special_ff;

    logic wr_en;
    logic rd_en;
    logic mapped;
    logic live_pwm;
    logic live_off;
    logic is_capture;
    logic is_compare;
    logic [15:0] tbase;
    logic cmp_match;
    logic cap_edge;
    logic cap_event;
    logic irq_set;
    logic irq_clr;
    logic [9:0] duty_new;
    unit_control_t eff;
    logic eff_pwm;
    logic inv_ac;
    logic inv_bd;
    logic [3:0] unit_val;
    logic [3:0] unit_own;

    ////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, error on unmapped offsets

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign mapped = (paddr == OFF_CONTROL) || (paddr == OFF_DATA_LOW) ||
                    (paddr == OFF_DATA_HIGH) || (paddr == OFF_STATUS) ||
                    (paddr == OFF_CONFIG);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_ff;

    // read data captured in the setup phase so it leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (rd_en) begin
            unique case (paddr)
                OFF_CONTROL: prdata_ff <= {24'h00_0000, unit_control_reg_ff};
                OFF_DATA_LOW: prdata_ff <= {24'h00_0000, unit_data_low_ff};
                OFF_DATA_HIGH: prdata_ff <= {24'h00_0000, unit_data_high_ff};
                OFF_STATUS: prdata_ff <= {30'h0000_0000, pwm_ff, irq_ff};
                OFF_CONFIG: prdata_ff <= {31'h0000_0000, time_base_ff};
                default: prdata_ff <= '0;
            endcase
        end
    end

    // control and time base select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_control_reg_ff <= CONTROL_RST;
            time_base_ff <= 1'b0;
        end else if (wr_en) begin
            if (paddr == OFF_CONTROL) begin
                unit_control_reg_ff <= pwdata[7:0];
            end
            if (paddr == OFF_CONFIG) begin
                time_base_ff <= pwdata[CFG_TBASE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode decode; reserved codes fall in no class

    assign live_pwm = unit_control_reg_ff.mode_select_field[3:2] ==
                      MODE_PWM_HI;
    assign live_off = unit_control_reg_ff.mode_select_field == MODE_OFF;
    assign is_capture = unit_control_reg_ff.mode_select_field[3:2] ==
                        2'b01;
    assign is_compare =
        (unit_control_reg_ff.mode_select_field == MODE_CMP_TOGGLE) ||
        (unit_control_reg_ff.mode_select_field[3:2] == 2'b10);
    assign tbase = time_base_ff ? timer_three : timer_one;

    ////////////////////////////////////////////////////////////////////
    // capture edge detect and prescale

    always_comb begin
        unique case (unit_control_reg_ff.mode_select_field)
            MODE_CAP_FALL: cap_edge = cap_prev_ff & ~capture_pin_in;
            MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16:
                cap_edge = ~cap_prev_ff & capture_pin_in;
            default: cap_edge = 1'b0;
        endcase
    end

    always_comb begin
        unique case (unit_control_reg_ff.mode_select_field)
            MODE_CAP_RISE4: cap_event = cap_edge && presc_ff == PRESC_LAST4;
            MODE_CAP_RISE16: cap_event = cap_edge && presc_ff == PRESC_LAST16;
            default: cap_event = cap_edge;
        endcase
    end

    // the prescaler restarts whenever software writes a different mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_ff <= '0;
            cap_prev_ff <= 1'b0;
        end else begin
            cap_prev_ff <= capture_pin_in;
            if (live_off || !is_capture ||
                (wr_en && paddr == OFF_CONTROL && pwdata[3:0] !=
                 unit_control_reg_ff.mode_select_field)) begin
                presc_ff <= '0;
            end else if (cap_event) begin
                presc_ff <= '0;
            end else if (cap_edge) begin
                presc_ff <= presc_ff + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare: one match pulse per equality episode

    assign cmp_match = is_compare && !cmp_eq_prev_ff &&
                       tbase == {unit_data_high_ff, unit_data_low_ff};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_eq_prev_ff <= 1'b0;
            pin_latch_ff <= 1'b0;
        end else if (live_off) begin
            cmp_eq_prev_ff <= 1'b0;
            pin_latch_ff <= 1'b0;
        end else begin
            cmp_eq_prev_ff <= is_compare &&
                tbase == {unit_data_high_ff, unit_data_low_ff};
            if (cmp_match) begin
                unique case (unit_control_reg_ff.mode_select_field)
                    MODE_CMP_TOGGLE: pin_latch_ff <= ~pin_latch_ff;
                    MODE_CMP_SET: pin_latch_ff <= 1'b1;
                    MODE_CMP_CLEAR: pin_latch_ff <= 1'b0;
                    default: pin_latch_ff <= pin_latch_ff;
                endcase
            end
        end
    end

    // special event pulses, one cycle after the match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            special_ff <= 1'b0;
        end else begin
            special_ff <= cmp_match && unit_control_reg_ff.mode_select_field
                          == MODE_CMP_SPECIAL;
        end
    end
    assign timer_one_clear = special_ff & ~time_base_ff;
    assign timer_three_clear = special_ff & time_base_ff;
    assign adc_start = special_ff & adc_enabled;

    ////////////////////////////////////////////////////////////////////
    // data register; hardware capture and pwm reload beat software

    assign duty_new = {unit_data_low_ff, unit_control_reg_ff.duty_low_bits};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_data_low_ff <= DATA_RST;
            unit_data_high_ff <= DATA_RST;
        end else if (cap_event) begin
            {unit_data_high_ff, unit_data_low_ff} <= tbase;
        end else begin
            if (wr_en && paddr == OFF_DATA_LOW) begin
                unit_data_low_ff <= pwdata[7:0];
            end
            if (live_pwm && timer_two_reset) begin
                unit_data_high_ff <= unit_data_low_ff;
            end else if (wr_en && paddr == OFF_DATA_HIGH) begin
                unit_data_high_ff <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flag: write one to clear, a set in the same cycle wins

    assign irq_set = cap_event || cmp_match;
    assign irq_clr = wr_en && paddr == OFF_STATUS && pwdata[STAT_IRQ_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else if (irq_set) begin
            irq_ff <= 1'b1;
        end else if (irq_clr) begin
            irq_ff <= 1'b0;
        end
    end
    assign unit_irq_flag = irq_ff;

    ////////////////////////////////////////////////////////////////////
    // pwm engine on timer two with double-buffered control and duty

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_act_ff <= CONTROL_RST;
            duty_act_ff <= '0;
            pwm_ff <= 1'b0;
        end else if (live_off) begin
            ctrl_act_ff <= CONTROL_RST;
            duty_act_ff <= '0;
            pwm_ff <= 1'b0;
        end else if (!live_pwm) begin
            ctrl_act_ff <= unit_control_reg_ff;
            pwm_ff <= 1'b0;
        end else if (timer_two_reset) begin
            ctrl_act_ff <= unit_control_reg_ff;
            duty_act_ff <= duty_new;
            pwm_ff <= duty_new != '0;
        end else if (pwm_ff &&
                     {timer_two, timer_two_phase} == duty_act_ff) begin
            pwm_ff <= 1'b0;
        end
    end

    // pwm waits for the period start; leaving pwm is immediate
    assign eff = live_pwm ? ctrl_act_ff : unit_control_reg_ff;
    assign eff_pwm = eff.mode_select_field[3:2] == MODE_PWM_HI;
    assign inv_ac = eff.mode_select_field[1];
    assign inv_bd = eff.mode_select_field[0];

    ////////////////////////////////////////////////////////////////////
    // output steering: value and ownership of pins a..d

    always_comb begin
        unit_val = {1'b0, 1'b0, 1'b0, pin_latch_ff};
        unit_own = 4'b0001;
        if (eff_pwm) begin
            unique case (eff.output_config_field)
                CFG_SINGLE: begin
                    unit_val = {3'b000, pwm_ff ^ inv_ac};
                    unit_own = 4'b0001;
                end
                CFG_FULL_FWD: begin
                    unit_val = {pwm_ff ^ inv_bd, inv_ac, inv_bd,
                                ~inv_ac};
                    unit_own = 4'b1111;
                end
                CFG_HALF: begin
                    unit_val = {2'b00, ~pwm_ff ^ inv_bd,
                                pwm_ff ^ inv_ac};
                    unit_own = 4'b0011;
                end
                CFG_FULL_REV: begin
                    unit_val = {inv_bd, ~inv_ac, pwm_ff ^ inv_bd,
                                inv_ac};
                    unit_own = 4'b1111;
                end
            endcase
        end
    end

    // owned pins override port and parallel slave port drive
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            assign pin_out[gi] = unit_own[gi] ? unit_val[gi]
                                              : port_side.data[gi];
            assign pin_oe[gi] = unit_own[gi] ? ~port_side.dir_input[gi]
                                             : port_side.oe[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // checks

    AST_OFF_CLEARS: assert property (@(posedge pclk)
        disable iff (!presetn) live_off |=> !pwm_ff && !pin_latch_ff)
        else $error("off mode left state set");
    AST_RESERVED_QUIET: assert property (@(posedge pclk)
        disable iff (!presetn)
        (unit_control_reg_ff.mode_select_field inside {4'h1, 4'h3})
        |-> !cmp_match && !cap_event)
        else $error("reserved mode produced an event");
    AST_TOGGLE: assert property (@(posedge pclk)
        disable iff (!presetn)
        cmp_match && unit_control_reg_ff.mode_select_field ==
        MODE_CMP_TOGGLE |=> pin_latch_ff != $past(pin_latch_ff) && irq_ff)
        else $error("toggle on match missing");
    AST_CAPTURE_LOAD: assert property (@(posedge pclk)
        disable iff (!presetn)
        cap_event |=> {unit_data_high_ff, unit_data_low_ff} == $past(tbase))
        else $error("capture did not load timer value");
    AST_SET_CLEAR: assert property (@(posedge pclk)
        disable iff (!presetn)
        cmp_match && unit_control_reg_ff.mode_select_field[3:1] == 3'b100
        |=> pin_latch_ff == ~$past(unit_control_reg_ff.mode_select_field[0]))
        else $error("set or clear on match wrong");
    AST_SPECIAL: assert property (@(posedge pclk)
        disable iff (!presetn)
        cmp_match && unit_control_reg_ff.mode_select_field ==
        MODE_CMP_SPECIAL |=> (timer_one_clear || timer_three_clear)
        ##1 !special_ff)
        else $error("special event pulse wrong");
    AST_FLAG_SET_WINS: assert property (@(posedge pclk)
        disable iff (!presetn) irq_set && irq_clr |=> irq_ff)
        else $error("flag clear beat a set");
    AST_NONPWM_PINS: assert property (@(posedge pclk)
        disable iff (!presetn)
        !live_pwm |-> pin_out[3:1] == port_side.data[3:1])
        else $error("non pwm mode took port pins");
    AST_DIR_GATE: assert property (@(posedge pclk)
        disable iff (!presetn)
        unit_own[0] && port_side.dir_input[0] |-> !pin_oe[0])
        else $error("pin driven while direction is input");
    AST_PERIOD_LOAD: assert property (@(posedge pclk)
        disable iff (!presetn)
        live_pwm && timer_two_reset |=> duty_act_ff == $past(duty_new))
        else $error("duty not buffered at period start");
    AST_PRESC_RESTART: assert property (@(posedge pclk)
        disable iff (!presetn)
        $changed(unit_control_reg_ff.mode_select_field) |-> presc_ff == '0)
        else $error("prescaler kept count across mode change");

    COV_CAPTURE16: cover property (@(posedge pclk) disable iff (!presetn)
        cap_event && unit_control_reg_ff.mode_select_field ==
        MODE_CAP_RISE16);
    COV_SPECIAL: cover property (@(posedge pclk) disable iff (!presetn)
        adc_start);
    COV_FULL_BRIDGE: cover property (@(posedge pclk) disable iff (!presetn)
        eff_pwm && eff.output_config_field == CFG_FULL_REV && pwm_ff);

endmodule // eccp_unit

// *** pkg/eccp_pkg.sv ***
/*
 * constants, register map and carrier types of the enhanced
 * capture/compare/pwm unit.
 * assumes a 32-bit apb register bus, 16-bit external timers one and three and an 8-bit timer two.
 */
package eccp_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_DATA_LOW = 8'h04;
    localparam logic [7:0] OFF_DATA_HIGH = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_CONFIG = 8'h10;

    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // status and config bit positions
    localparam int STAT_IRQ_BIT = 0;
    localparam int STAT_PWM_BIT = 1;
    localparam int CFG_TBASE_BIT = 0;

    // mode select codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_NONE = 4'ha;
    localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
    localparam logic [1:0] MODE_PWM_HI = 2'h3;

    // output configurations in pwm
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    localparam logic [1:0] CFG_FULL_FWD = 2'h1;
    localparam logic [1:0] CFG_HALF = 2'h2;
    localparam logic [1:0] CFG_FULL_REV = 2'h3;

    // capture edge prescale terminal counts
    localparam logic [3:0] PRESC_LAST4 = 4'h3;
    localparam logic [3:0] PRESC_LAST16 = 4'hf;

    // control register layout
    typedef struct packed {
        logic [1:0] output_config_field;
        logic [1:0] duty_low_bits;
        logic [3:0] mode_select_field;
    } unit_control_t;

    // one shared port pin group as seen by the port logic
    typedef struct packed {
        logic [3:0] dir_input;
        logic [3:0] data;
        logic [3:0] oe;
    } port_side_t;

endpackage

// *** verification/far_side_model.sv ***
/*
 * far side of the unit: timer two time base and the capture pin source.
 * assumes the bench asks for a period start with kick and sets the
 * capture level with cap_cmd, both changed right after a rising edge.
 */
`timescale 1ns/1ps
module far_side_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench commands
    input wire logic kick,
    input wire logic cap_cmd,
    // toward the unit
    output logic [7:0] timer_two,
    output logic [1:0] timer_two_phase,
    output logic timer_two_reset,
    output logic capture_pin_in
);
    logic [9:0] cnt_ff;
    // count saturates so no period start appears without a kick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 10'h3ff;
            timer_two_reset <= 1'b0;
            capture_pin_in <= 1'b0;
        end else begin
            timer_two_reset <= kick;
            capture_pin_in <= cap_cmd;
            if (kick) begin
                cnt_ff <= 10'h000;
            end else if (cnt_ff != 10'h3ff) begin
                cnt_ff <= cnt_ff + 10'h001;
            end
        end
    end
    assign {timer_two, timer_two_phase} = cnt_ff;
endmodule // far_side_model

// *** verification/enhanced_capture_compare_pwm_test.sv ***
/*
 * self-checking bench: apb register access, compare, capture and pwm.
 * assumes eccp_unit with zero-wait apb and far_side_model beside it.
 */
`timescale 1ns/1ps
module enhanced_capture_compare_pwm_test import eccp_pkg::*;;
    localparam logic [3:0] PD = 4'hb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, kick = 1'b0, cap_cmd = 1'b0, pin_req = 1'b0;
    logic adc_enabled = 1'b0, f = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [15:0] timer_one = 16'h0000, timer_three = 16'h0000;
    port_side_t port_side = {4'h0, PD, 4'hf};
    logic pready, pslverr, timer_one_clear, timer_three_clear, adc_start;
    logic capture_pin_in, unit_irq_flag, timer_two_reset;
    logic [31:0] prdata, r;
    logic [7:0] timer_two, c, a, prev;
    logic [1:0] timer_two_phase;
    logic [3:0] pin_out, pin_oe, q;
    logic [1:0] n1 = 2'h0, n3 = 2'h0, na = 2'h0;
    logic [1:0] e1 = 2'h0, e3 = 2'h0, ea = 2'h0;
    logic [15:0] cv, ev;
    logic [3:0] cm [7] = '{4'h8, 4'h1, 4'h2, 4'h9, 4'h3, 4'h2, 4'ha};
    logic [6:0] lat = 7'h63, fl = 7'h6d;
    logic [32:0] rq [$];
    logic [14:0] pq [$];
    int err_total = 0, checked = 0, cyc = 0;

    eccp_unit eccp_unit_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_one,
        .timer_three, .timer_two, .timer_two_phase, .timer_two_reset,
        .timer_one_clear, .timer_three_clear, .adc_enabled, .adc_start,
        .capture_pin_in, .port_side, .pin_out, .pin_oe, .unit_irq_flag);
    far_side_model far_side_model_inst (.pclk, .presetn, .kick, .cap_cmd,
        .timer_two, .timer_two_phase, .timer_two_reset, .capture_pin_in);

    initial begin
        forever #2 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("FAIL read exp %h got %h", e, g);
        end
    endtask

    task automatic cmp_pin(input logic [14:0] e, input logic [14:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("FAIL pins exp %h got %h", e, g);
        end
    endtask

    // one apb transfer; idle edge after so psel is never set twice at once
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, ad, 32'h0000_0000);
    endtask

    // p is {ownership, pins}; an owned pin drives only when direction is out
    task automatic chk(input logic [7:0] p);
        pq.push_back({f, ea, e3, e1,
                      ~(p[7:4] & port_side.dir_input), p[3:0]});
        pin_req <= 1'b1;
        @(posedge pclk);
        pin_req <= 1'b0;
        @(posedge pclk);
    endtask

    // ownership and pins {d,c,b,a} in pwm for control k and raw level p
    function automatic logic [7:0] pwm_pins(input logic [7:0] k,
                                            input logic p);
        case (k[7:6])
            2'h0: return {4'h1, PD[3:1], p ^ k[1]};
            2'h1: return {4'hf, p ^ k[0], k[1], k[0], ~k[1]};
            2'h2: return {4'h3, PD[3:2], ~p ^ k[0], p ^ k[1]};
            default: return {4'hf, k[0], ~k[1], p ^ k[0], k[1]};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // watcher: pops the oldest note when a result shows; also the timeout
    always @(posedge pclk) begin
        cyc++;
        if (psel && penable && pready && !pwrite)
            cmp_rd(rq.pop_front(), {pslverr, prdata});
        if (pin_req)
            cmp_pin(pq.pop_front(),
                    {unit_irq_flag, na, n3, n1, pin_oe, pin_out});
        if (cyc == 8000) begin
            err_total++;
            close_out();
        end
    end

    // pulse counters for the special event outputs
    always @(posedge pclk) begin
        n1 <= n1 + {1'b0, timer_one_clear};
        n3 <= n3 + {1'b0, timer_three_clear};
        na <= na + {1'b0, adc_start};
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(6990));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 3; i++) begin
            r = $urandom;
            r[3:0] = (i == 0) ? 4'h0 : r[3:0];
            a = 8'(4 * i);
            rd(a, 33'h0_0000_0000);
            apb(1'b1, a, r);
            rd(a, {25'h0, r[7:0]});
        end
        rd(8'h14, {1'b1, 32'h0000_0000});
        r = $urandom;
        cv = r[15:0];
        timer_one <= ~cv;
        timer_three <= ~cv;
        apb(1'b1, OFF_DATA_LOW, {24'h0, cv[7:0]});
        apb(1'b1, OFF_DATA_HIGH, {24'h0, cv[15:8]});
        // compare table; output config bits set to show they are ignored
        for (int i = 0; i < 9; i++) begin
            adc_enabled <= (i == 7);
            apb(1'b1, OFF_CONFIG, {31'h0, i == 8});
            c = (i < 7) ? {4'hc, cm[i]} : 8'h0b;
            apb(1'b1, OFF_CONTROL, {24'h0, c});
            if (i == 8)
                timer_three <= cv;
            else
                timer_one <= cv;
            repeat (2) @(posedge pclk);
            timer_one <= ~cv;
            timer_three <= ~cv;
            repeat (2) @(posedge pclk);
            e1 = e1 + {1'b0, i == 7};
            ea = ea + {1'b0, i == 7};
            e3 = e3 + {1'b0, i == 8};
            f = (i < 7) ? fl[i] : 1'b1;
            chk({4'h1, PD[3:1], (i < 7) ? lat[i] : 1'b1});
            rd(OFF_STATUS, {32'h0, f});
            apb(1'b1, OFF_STATUS, 32'h0000_0001);
        end
        // clear and a new match land at one edge: the set must win
        fork
            apb(1'b1, OFF_STATUS, 32'h0000_0001);
            begin
                @(posedge pclk);
                timer_three <= cv;
            end
        join
        e3 = e3 + 2'h1;
        rd(OFF_STATUS, 33'h0_0000_0001);
        apb(1'b1, OFF_STATUS, 32'h0000_0001);
        f = 1'b0;
        // capture below reads timer one again
        apb(1'b1, OFF_CONFIG, 32'h0000_0000);
        apb(1'b1, OFF_CONTROL, 32'h0000_0000);
        chk({4'h1, PD[3:1], 1'b0});
        // capture modes 4..7 with 1, 1, 4 and 16 edges
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFF_CONTROL, 32'(4 + i));
            for (int k = 0; k < ((i < 2) ? 1 : 4 ** (i - 1)); k++) begin
                timer_one <= cv + 16'(16 * i + k);
                cap_cmd <= 1'b1;
                repeat (3) @(posedge pclk);
                cap_cmd <= 1'b0;
                repeat (3) @(posedge pclk);
            end
            ev = cv + 16'(16 * i + ((i < 2) ? 1 : 4 ** (i - 1)) - 1);
            rd(OFF_DATA_LOW, {25'h0, ev[7:0]});
            rd(OFF_DATA_HIGH, {25'h0, ev[15:8]});
            rd(OFF_STATUS, 33'h0_0000_0001);
            apb(1'b1, OFF_STATUS, 32'h0000_0001);
        end
        // pwm: duty 0x2a5, every config and polarity, loaded at kick only
        apb(1'b1, OFF_DATA_LOW, 32'h0000_00a9);
        prev = {4'h1, PD[3:1], 1'b0};
        for (int i = 0; i < 16; i++) begin
            q = 4'(i);
            port_side.dir_input <= 4'($urandom);
            c = {q[3:2], 4'h7, q[1:0]};
            apb(1'b1, OFF_CONTROL, {24'h0, c});
            chk(prev);
            kick <= 1'b1;
            @(posedge pclk);
            kick <= 1'b0;
            repeat (3) @(posedge pclk);
            prev = pwm_pins(c, 1'b1);
            chk(prev);
        end
        repeat (600) @(posedge pclk);
        chk(prev);
        repeat (100) @(posedge pclk);
        chk(pwm_pins(c, 1'b0));
        close_out();
    end
endmodule // enhanced_capture_compare_pwm_test
